// ---- logic/uspc_pkg.sv ----
// Shared constants and types for the suspend and streaming control block.
package uspc_pkg;
   // Widths of the transceiver power-down word and of the FIFO counts.
   localparam int USPC_PWD_W = 20;
   localparam int USPC_LVL_W = 10;
   localparam int USPC_THR_W = 6;
   // Values after reset, and the all-ones power-down word.
   localparam logic USPC_CLK_DIS_RST = 1'b0;
   localparam logic USPC_GATE_RST = 1'b0;
   localparam logic [USPC_PWD_W-1:0] USPC_PWD_RST = 20'h00000;
   localparam logic [USPC_PWD_W-1:0] USPC_PWD_ALL = 20'hFFFFF;
   localparam logic [USPC_LVL_W-1:0] USPC_LVL_ZERO = 10'h000;
   // One fill-threshold step stands for 2 to the power of this many FIFO entries.
   localparam int USPC_THR_SHIFT = 2;
   // Transmit sequencer states, in Gray code order; IDLE to FILL to SEND steps one bit at a time.
   typedef enum logic [1:0] {
      USPC_TX_IDLE = 2'b00,
      USPC_TX_FILL = 2'b01,
      USPC_TX_SEND = 2'b11,
      USPC_TX_RETRY = 2'b10
   } uspc_tx_state_t;
endpackage

// ---- logic/uspc_fill_check.sv ----
// Registered comparison of a FIFO count against a needed amount.
`timescale 1ns/1ns
module uspc_fill_check
   import uspc_pkg::*;
#(
   parameter int LW = USPC_LVL_W
)
(
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic [LW-1:0] level_in,
   input wire logic [LW-1:0] need_in,
   output logic enough_out
);
   logic enough_d;
   logic enough_q;

   // A zero need never counts as enough, so an empty packet waits.
   always_comb
   begin
      enough_d = (need_in != '0) && (level_in >= need_in);
   end

   // Registered so that the caller sees a clean, one-cycle-late level.
   always_ff @(posedge clk_in)
   begin
      if (!resetn_in)
         enough_q <= 1'b0;
      else
         enough_q <= enough_d;
   end

   assign enough_out = enough_q;
endmodule // uspc_fill_check

// ---- logic/uspc_ctl.sv ----
// Suspend, resume and FIFO streaming control for a dual-role USB port.
`timescale 1ns/1ns
module uspc_ctl
   import uspc_pkg::*;
#(
   parameter int PWD_W = USPC_PWD_W,
   parameter int LW = USPC_LVL_W,
   parameter int TW = USPC_THR_W
)
(
   input wire logic SYS_CLK_IN,
   input wire logic RESETN_IN,
   input wire logic ROLE_HOST_IN,
   input wire logic STREAM_DISABLE_IN,
   input wire logic [TW-1:0] TX_FIFO_FILL_THRESHOLD_IN,
   input wire logic CLK_DIS_SET_IN,
   input wire logic CLK_DIS_CLR_IN,
   input wire logic PWD_WR_IN,
   input wire logic [PWD_W-1:0] PWD_DATA_IN,
   input wire logic CLK_GATE_WR_IN,
   input wire logic CLK_GATE_DATA_IN,
   input wire logic DEVICE_IDLE_IN,
   input wire logic HOST_SUSPEND_IN,
   input wire logic HOST_RESUME_IN,
   input wire logic PORT_SUSPEND_IN,
   input wire logic DEV_ATTACHED_IN,
   input wire logic REMOTE_WAKE_IN,
   input wire logic TX_REQ_IN,
   input wire logic [LW-1:0] TX_PKT_LEN_IN,
   input wire logic [LW-1:0] TX_FIFO_LEVEL_IN,
   input wire logic TX_BYTE_SENT_IN,
   input wire logic [LW-1:0] RX_FIFO_FREE_IN,
   input wire logic [LW-1:0] RX_MAX_PKT_IN,
   input wire logic RX_WRITE_IN,
   input wire logic RX_TOKEN_IN,
   output logic CLK_DIS_OUT,
   output logic [PWD_W-1:0] PWD_OUT,
   output logic CLK_GATE_OUT,
   output logic PORT_CHANGE_IRQ_OUT,
   output logic REMOTE_WAKE_IRQ_OUT,
   output logic TX_START_OUT,
   output logic TX_RETRY_OUT,
   output logic TX_DONE_OUT,
   output logic TX_BUSY_OUT,
   output logic RX_OVERRUN_OUT,
   output logic TOKEN_ACK_OUT,
   output logic TOKEN_NAK_OUT
);
   // Low-power control state.
   logic clk_dis_d, clk_dis_q;
   logic [PWD_W-1:0] pwd_d, pwd_q;
   logic gate_d, gate_q;
   logic pci_d, pci_q;
   logic rwk_d, rwk_q;
   logic suspend_ok;

   // Transmit sequencer state.
   uspc_tx_state_t tx_st_d, tx_st_q;
   logic [LW-1:0] tx_left_d, tx_left_q;
   logic [LW-1:0] tx_need;
   logic [LW-1:0] thr_entries;
   logic tx_enough;
   logic tx_start_d, tx_start_q;
   logic tx_retry_d, tx_retry_q;
   logic tx_done_d, tx_done_q, tx_busy_d, tx_busy_q;
   logic underrun;

   // Receive side state.
   logic ovr_d, ovr_q;
   logic rx_room;
   logic ack_d, ack_q;
   logic nak_d, nak_q;

   // The role decides which bus condition makes suspend legal.
   always_comb
   begin
      if (ROLE_HOST_IN)
         suspend_ok = PORT_SUSPEND_IN || !DEV_ATTACHED_IN;
      else
         suspend_ok = DEVICE_IDLE_IN || HOST_SUSPEND_IN;
   end

   // Next values of the low-power bits and the two wake interrupts.
   // The power-down word and clock gate change only by software writes,
   // so a wake leaves the transceiver powered and clocked as software last set it.
   always_comb
   begin
      clk_dis_d = clk_dis_q;
      pwd_d = pwd_q;
      gate_d = gate_q;
      pci_d = 1'b0;
      rwk_d = 1'b0;
      // Setting is software-only and refused while suspend is illegal.
      if (CLK_DIS_SET_IN && suspend_ok)
         clk_dis_d = 1'b1;
      if (CLK_DIS_CLR_IN)
         clk_dis_d = 1'b0;
      // A host-driven resume wakes the transceiver on its own.
      if (!ROLE_HOST_IN && HOST_RESUME_IN && clk_dis_q)
         clk_dis_d = 1'b0;
      if (PWD_WR_IN)
         pwd_d = PWD_DATA_IN;
      if (CLK_GATE_WR_IN)
         gate_d = CLK_GATE_DATA_IN;
      if (REMOTE_WAKE_IN && PORT_SUSPEND_IN && !clk_dis_q)
         pci_d = 1'b1;
      if (REMOTE_WAKE_IN && clk_dis_q && (pwd_q == '0) && !gate_q)
         rwk_d = 1'b1;
   end

   // Registers of the low-power group.
   always_ff @(posedge SYS_CLK_IN)
   begin
      if (!RESETN_IN)
      begin
         clk_dis_q <= USPC_CLK_DIS_RST;
         pwd_q <= USPC_PWD_RST;
         gate_q <= USPC_GATE_RST;
         pci_q <= 1'b0;
         rwk_q <= 1'b0;
      end
      else
      begin
         clk_dis_q <= clk_dis_d;
         pwd_q <= pwd_d;
         gate_q <= gate_d;
         pci_q <= pci_d;
         rwk_q <= rwk_d;
      end
   end

   // Threshold in entries; a large value buys bus latency for a late start.
   assign thr_entries = LW'({TX_FIFO_FILL_THRESHOLD_IN, 2'b00});

   // Amount to hold before sending: whole packet when streaming is off.
   always_comb
   begin
      if (STREAM_DISABLE_IN || (thr_entries >= tx_left_q))
         tx_need = tx_left_q;
      else
         tx_need = thr_entries;
   end

   uspc_fill_check #(.LW(LW)) u_tx_fill (
      .clk_in(SYS_CLK_IN),
      .resetn_in(RESETN_IN),
      .level_in(TX_FIFO_LEVEL_IN),
      .need_in(tx_need),
      .enough_out(tx_enough)
   );

   // Starved FIFO with bytes still owed; whole-packet mode never gets here.
   assign underrun = (TX_FIFO_LEVEL_IN == USPC_LVL_ZERO) &&
                     !TX_BYTE_SENT_IN && (tx_left_q != USPC_LVL_ZERO);

   // Transmit sequencer for host OUT data packets.
   always_comb
   begin
      tx_st_d = tx_st_q;
      tx_left_d = tx_left_q;
      tx_start_d = 1'b0;
      tx_retry_d = 1'b0;
      tx_done_d = 1'b0;
      unique case (tx_st_q)
         USPC_TX_IDLE:
         begin
            if (TX_REQ_IN && ROLE_HOST_IN)
            begin
               tx_left_d = TX_PKT_LEN_IN;
               tx_st_d = USPC_TX_FILL;
            end
         end
         USPC_TX_FILL:
         begin
            if (tx_enough)
            begin
               tx_start_d = 1'b1;
               tx_st_d = USPC_TX_SEND;
            end
         end
         USPC_TX_SEND:
         begin
            if (TX_BYTE_SENT_IN)
               tx_left_d = tx_left_q - LW'(1);
            if (TX_BYTE_SENT_IN && (tx_left_q == LW'(1)))
            begin
               tx_done_d = 1'b1;
               tx_st_d = USPC_TX_IDLE;
            end
            else if (!STREAM_DISABLE_IN && underrun)
            begin
               tx_retry_d = 1'b1;
               tx_st_d = USPC_TX_RETRY;
            end
         end
         USPC_TX_RETRY:
         begin
            // The whole OUT transaction is reissued from its first byte.
            tx_left_d = TX_PKT_LEN_IN;
            tx_st_d = USPC_TX_FILL;
         end
      endcase
      tx_busy_d = (tx_st_d != USPC_TX_IDLE);
   end

   // Registers of the transmit group.
   always_ff @(posedge SYS_CLK_IN)
   begin
      if (!RESETN_IN)
      begin
         tx_st_q <= USPC_TX_IDLE;
         tx_left_q <= USPC_LVL_ZERO;
         tx_start_q <= 1'b0;
         tx_retry_q <= 1'b0;
         tx_done_q <= 1'b0;
         tx_busy_q <= 1'b0;
      end
      else
      begin
         tx_st_q <= tx_st_d;
         tx_left_q <= tx_left_d;
         tx_start_q <= tx_start_d;
         tx_retry_q <= tx_retry_d;
         tx_done_q <= tx_done_d;
         tx_busy_q <= tx_busy_d;
      end
   end

   uspc_fill_check #(.LW(LW)) u_rx_room (
      .clk_in(SYS_CLK_IN),
      .resetn_in(RESETN_IN),
      .level_in(RX_FIFO_FREE_IN),
      .need_in(RX_MAX_PKT_IN),
      .enough_out(rx_room)
   );

   // Device answers; with streaming off a token needs room for a packet.
   always_comb
   begin
      ovr_d = ovr_q;
      ack_d = 1'b0;
      nak_d = 1'b0;
      if (RX_WRITE_IN && (RX_FIFO_FREE_IN == USPC_LVL_ZERO))
         ovr_d = 1'b1;
      else if (RX_FIFO_FREE_IN != USPC_LVL_ZERO)
         ovr_d = 1'b0;
      if (RX_TOKEN_IN && !ROLE_HOST_IN && !ovr_q)
      begin
         if (STREAM_DISABLE_IN && !rx_room)
            nak_d = 1'b1;
         else
            ack_d = 1'b1;
      end
   end

   // Registers of the receive group.
   always_ff @(posedge SYS_CLK_IN)
   begin
      if (!RESETN_IN)
      begin
         ovr_q <= 1'b0;
         ack_q <= 1'b0;
         nak_q <= 1'b0;
      end
      else
      begin
         ovr_q <= ovr_d;
         ack_q <= ack_d;
         nak_q <= nak_d;
      end
   end

   // Every output is a flip-flop.
   assign CLK_DIS_OUT = clk_dis_q;
   assign PWD_OUT = pwd_q;
   assign CLK_GATE_OUT = gate_q;
   assign PORT_CHANGE_IRQ_OUT = pci_q;
   assign REMOTE_WAKE_IRQ_OUT = rwk_q;
   assign TX_START_OUT = tx_start_q;
   assign TX_RETRY_OUT = tx_retry_q;
   assign TX_DONE_OUT = tx_done_q;
   assign TX_BUSY_OUT = tx_busy_q;
   assign RX_OVERRUN_OUT = ovr_q;
   assign TOKEN_ACK_OUT = ack_q;
   assign TOKEN_NAK_OUT = nak_q;
endmodule // uspc_ctl

// ---- verif/uspc_ctl_assertions.sv ----
// Port checker for the suspend and streaming control block.
`timescale 1ns/1ns
module uspc_chk
(
   input wire logic SYS_CLK_IN,
   input wire logic RESETN_IN,
   input wire logic ROLE_HOST_IN,
   input wire logic CLK_DIS_SET_IN,
   input wire logic CLK_DIS_CLR_IN,
   input wire logic DEVICE_IDLE_IN,
   input wire logic HOST_SUSPEND_IN,
   input wire logic HOST_RESUME_IN,
   input wire logic PORT_SUSPEND_IN,
   input wire logic DEV_ATTACHED_IN,
   input wire logic REMOTE_WAKE_IN,
   input wire logic PWD_WR_IN,
   input wire logic CLK_GATE_WR_IN,
   input wire logic RX_TOKEN_IN,
   input wire logic CLK_DIS_OUT,
   input wire logic [19:0] PWD_OUT,
   input wire logic CLK_GATE_OUT,
   input wire logic PORT_CHANGE_IRQ_OUT,
   input wire logic REMOTE_WAKE_IRQ_OUT,
   input wire logic RX_OVERRUN_OUT,
   input wire logic TOKEN_ACK_OUT,
   input wire logic TOKEN_NAK_OUT
);
   default clocking dc @(posedge SYS_CLK_IN);
   endclocking
   default disable iff (!RESETN_IN);
   // Set, resume and port-change cases exclude each other so that no two collide.
   dev_set_a: assert property (!ROLE_HOST_IN && CLK_DIS_SET_IN &&
      !CLK_DIS_CLR_IN && !HOST_RESUME_IN && (DEVICE_IDLE_IN ||
      HOST_SUSPEND_IN) |=> CLK_DIS_OUT) else $error("clock disable not set");
   host_refuse_a: assert property (ROLE_HOST_IN && !CLK_DIS_OUT &&
      DEV_ATTACHED_IN && !PORT_SUSPEND_IN |=> !CLK_DIS_OUT)
      else $error("host suspend entered while port active");
   resume_clear_a: assert property (!ROLE_HOST_IN && CLK_DIS_OUT &&
      HOST_RESUME_IN && !CLK_DIS_SET_IN |=> !CLK_DIS_OUT)
      else $error("resume left clock disable set");
   pwd_hold_a: assert property (!PWD_WR_IN |=> $stable(PWD_OUT))
      else $error("power-down word changed without a write");
   gate_hold_a: assert property (!CLK_GATE_WR_IN |=>
      $stable(CLK_GATE_OUT)) else $error("clock gate changed without a write");
   port_chg_a: assert property (REMOTE_WAKE_IN && PORT_SUSPEND_IN &&
      !CLK_DIS_OUT && !CLK_DIS_SET_IN |=> PORT_CHANGE_IRQ_OUT && !CLK_DIS_OUT)
      else $error("port change interrupt missing");
   wake_irq_a: assert property (REMOTE_WAKE_IN && CLK_DIS_OUT &&
      PWD_OUT == 20'h00000 && !CLK_GATE_OUT |=> REMOTE_WAKE_IRQ_OUT)
      else $error("remote wakeup interrupt missing");
   token_ans_a: assert property (RX_TOKEN_IN && !ROLE_HOST_IN &&
      !RX_OVERRUN_OUT |=> TOKEN_ACK_OUT ^ TOKEN_NAK_OUT)
      else $error("token left without one answer");
endmodule // uspc_chk
bind uspc_ctl uspc_chk chk (.*);

// ---- verif/uspc_bus_model.sv ----
// Far-end bus model that takes transmit entries off the wire.
`timescale 1ns/1ns
module uspc_bus_model
(
   input wire logic clk_in,
   input wire logic start_in,
   input wire logic stop_in,
   input wire logic slow_in,
   input wire logic [9:0] level_in,
   output logic byte_out
);
   logic go_q = 1'b0;
   logic tick_q = 1'b0;
   initial byte_out = 1'b0;
   // Entries leave only while data waits; an empty FIFO starves the wire.
   always @(posedge clk_in)
   begin
      tick_q <= ~tick_q;
      go_q <= (go_q | start_in) & ~stop_in;
      byte_out <= go_q && !stop_in && level_in != 10'h000 &&
         (!slow_in || tick_q);
   end
endmodule // uspc_bus_model

// ---- verif/tb_top.sv ----
// Self-checking bench for the suspend and streaming control block.
`timescale 1ns/1ns
module tb_top;
   import uspc_pkg::*;
   logic SYS_CLK_IN = 1'b0;
   logic RESETN_IN = 1'b0;
   logic ROLE_HOST_IN, STREAM_DISABLE_IN, CLK_DIS_SET_IN, CLK_DIS_CLR_IN;
   logic PWD_WR_IN, CLK_GATE_WR_IN, CLK_GATE_DATA_IN, DEVICE_IDLE_IN;
   logic HOST_SUSPEND_IN, HOST_RESUME_IN, PORT_SUSPEND_IN, DEV_ATTACHED_IN;
   logic REMOTE_WAKE_IN, TX_REQ_IN, TX_BYTE_SENT_IN, RX_WRITE_IN, RX_TOKEN_IN;
   logic [5:0] TX_FIFO_FILL_THRESHOLD_IN;
   logic [19:0] PWD_DATA_IN, PWD_OUT;
   logic [9:0] TX_PKT_LEN_IN, TX_FIFO_LEVEL_IN, RX_FIFO_FREE_IN, RX_MAX_PKT_IN;
   logic CLK_DIS_OUT, CLK_GATE_OUT, PORT_CHANGE_IRQ_OUT, REMOTE_WAKE_IRQ_OUT;
   logic TX_START_OUT, TX_RETRY_OUT, TX_DONE_OUT, TX_BUSY_OUT, RX_OVERRUN_OUT;
   logic TOKEN_ACK_OUT, TOKEN_NAK_OUT, slow;
   logic [6:0] exq[$];
   logic [7:0] lf = 8'h04;
   int bad_count = 0;
   int tests_run = 0;
   uspc_ctl dut (.*);
   uspc_bus_model far (.clk_in(SYS_CLK_IN), .start_in(TX_START_OUT),
      .stop_in(TX_RETRY_OUT | TX_DONE_OUT), .slow_in(slow),
      .level_in(TX_FIFO_LEVEL_IN), .byte_out(TX_BYTE_SENT_IN));
   // Free-running clock of 8 ns.
   always #4 SYS_CLK_IN = ~SYS_CLK_IN;
   function automatic logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   task automatic chk(input string n, input logic [19:0] e, g);
      tests_run++;
      if (g !== e)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // A gap cycle follows each pulse so a strobe is never driven twice.
   task automatic pul(ref logic s);
      s = 1'b1;
      @(negedge SYS_CLK_IN);
      s = 1'b0;
      @(negedge SYS_CLK_IN);
   endtask
   task automatic drain(input string n);
      for (int i = 0; i < 200 && exq.size() != 0; i++)
         @(negedge SYS_CLK_IN);
      chk("pending events", 20'h00000, 20'(exq.size()));
      $display("test %s ended", n);
      if (exq.size() != 0)
         give_verdict();
   endtask
   // Every event pulse is matched, in order, against the oldest note.
   always @(negedge SYS_CLK_IN)
      if (RESETN_IN && {PORT_CHANGE_IRQ_OUT, REMOTE_WAKE_IRQ_OUT, TX_START_OUT,
         TX_RETRY_OUT, TX_DONE_OUT, TOKEN_ACK_OUT, TOKEN_NAK_OUT} !== 7'h00)
         chk("event", exq.size() ? exq.pop_front() : 7'h00,
            {PORT_CHANGE_IRQ_OUT, REMOTE_WAKE_IRQ_OUT, TX_START_OUT,
            TX_RETRY_OUT, TX_DONE_OUT, TOKEN_ACK_OUT, TOKEN_NAK_OUT});
   // Main sequence: reset, low power, transmit, then receive.
   initial
   begin
      {ROLE_HOST_IN, STREAM_DISABLE_IN, CLK_DIS_SET_IN, CLK_DIS_CLR_IN,
         PWD_WR_IN, CLK_GATE_WR_IN, CLK_GATE_DATA_IN, DEVICE_IDLE_IN,
         HOST_SUSPEND_IN, HOST_RESUME_IN, PORT_SUSPEND_IN, DEV_ATTACHED_IN,
         REMOTE_WAKE_IN, TX_REQ_IN, RX_WRITE_IN, RX_TOKEN_IN, slow} = '0;
      {TX_FIFO_FILL_THRESHOLD_IN, TX_PKT_LEN_IN, TX_FIFO_LEVEL_IN} = '0;
      PWD_DATA_IN = USPC_PWD_ALL;
      RX_FIFO_FREE_IN = 10'h100;
      RX_MAX_PKT_IN = 10'h040;
      repeat (4) @(negedge SYS_CLK_IN);
      RESETN_IN = 1'b1;
      chk("power-down", USPC_PWD_RST, PWD_OUT);
      pul(CLK_DIS_SET_IN);
      chk("clock disable", 20'h0, CLK_DIS_OUT);
      DEVICE_IDLE_IN = 1'b1;
      pul(CLK_DIS_SET_IN);
      chk("clock disable", 20'h1, CLK_DIS_OUT);
      exq.push_back(7'h20);
      pul(REMOTE_WAKE_IN);
      chk("power-down", USPC_PWD_RST, PWD_OUT);
      chk("clock gate", 20'h0, CLK_GATE_OUT);
      HOST_RESUME_IN = 1'b1;
      @(negedge SYS_CLK_IN);
      chk("clock disable", 20'h0, CLK_DIS_OUT);
      {HOST_RESUME_IN, DEVICE_IDLE_IN, PORT_SUSPEND_IN} = 3'h1;
      exq.push_back(7'h40);
      pul(REMOTE_WAKE_IN);
      chk("clock disable", 20'h0, CLK_DIS_OUT);
      HOST_SUSPEND_IN = 1'b1;
      pul(CLK_DIS_SET_IN);
      chk("clock disable", 20'h1, CLK_DIS_OUT);
      pul(CLK_DIS_CLR_IN);
      chk("clock disable", 20'h0, CLK_DIS_OUT);
      drain("device suspend");
      {ROLE_HOST_IN, PORT_SUSPEND_IN, DEV_ATTACHED_IN} = 3'h5;
      pul(CLK_DIS_SET_IN);
      chk("clock disable", 20'h0, CLK_DIS_OUT);
      DEV_ATTACHED_IN = 1'b0;
      pul(CLK_DIS_SET_IN);
      chk("clock disable", 20'h1, CLK_DIS_OUT);
      pul(PWD_WR_IN);
      chk("power-down", USPC_PWD_ALL, PWD_OUT);
      CLK_GATE_DATA_IN = 1'b1;
      pul(CLK_GATE_WR_IN);
      chk("clock gate", 20'h1, CLK_GATE_OUT);
      drain("host suspend");
      // Whole-packet mode: no start until every entry is loaded.
      STREAM_DISABLE_IN = 1'b1;
      for (int k = 0; k < 3; k++)
      begin
         lf = lfsr(lf);
         slow = k[0];
         TX_PKT_LEN_IN = {6'h00, lf[3:0]} + 10'h004;
         TX_FIFO_LEVEL_IN = TX_PKT_LEN_IN - 10'h001;
         exq = '{7'h10, 7'h04};
         pul(TX_REQ_IN);
         repeat (6) @(negedge SYS_CLK_IN);
         chk("events left", 20'h2, 20'(exq.size()));
         chk("busy", 20'h1, TX_BUSY_OUT);
         TX_FIFO_LEVEL_IN = TX_PKT_LEN_IN;
         drain("whole packet");
      end
      // Streaming with a threshold of 4 entries, then an underrun.
      {STREAM_DISABLE_IN, slow} = 2'h0;
      TX_FIFO_FILL_THRESHOLD_IN = 6'h01;
      TX_PKT_LEN_IN = 10'h00C;
      TX_FIFO_LEVEL_IN = 10'h003;
      exq = '{7'h10, 7'h08, 7'h10, 7'h04};
      pul(TX_REQ_IN);
      repeat (6) @(negedge SYS_CLK_IN);
      chk("events left", 20'h4, 20'(exq.size()));
      TX_FIFO_LEVEL_IN = 10'h004;
      repeat (4) @(negedge SYS_CLK_IN);
      TX_FIFO_LEVEL_IN = 10'h000;
      repeat (6) @(negedge SYS_CLK_IN);
      TX_FIFO_LEVEL_IN = 10'h00C;
      drain("underrun retry");
      // Receive: answer, room refusal, overrun silence, recovery.
      ROLE_HOST_IN = 1'b0;
      STREAM_DISABLE_IN = 1'b1;
      pul(TX_REQ_IN);
      chk("busy", 20'h0, TX_BUSY_OUT);
      exq = '{7'h02, 7'h01, 7'h02};
      pul(RX_TOKEN_IN);
      RX_FIFO_FREE_IN = 10'h020;
      @(negedge SYS_CLK_IN);
      pul(RX_TOKEN_IN);
      RX_FIFO_FREE_IN = 10'h000;
      pul(RX_WRITE_IN);
      chk("overrun", 20'h1, RX_OVERRUN_OUT);
      pul(RX_TOKEN_IN);
      RX_FIFO_FREE_IN = 10'h100;
      repeat (2) @(negedge SYS_CLK_IN);
      chk("overrun", 20'h0, RX_OVERRUN_OUT);
      pul(RX_TOKEN_IN);
      drain("receive");
      give_verdict();
   end
endmodule // tb_top
